// >>> pkg/nel_pkg.sv
/*
 * Constants for the NAND error-locator result registers: register byte
 * addresses, field positions, segment page ranges, bus response codes.
 * Assumes a 32-bit AXI4-Lite bus and 256-byte segments in a page.
 */
package nel_pkg;

	// Bus widths
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 32;

	// Page byte address width and segment geometry
	localparam int unsigned PAGE_ADDR_W = 12;
	localparam int unsigned SEG_LSB     = 8;
	localparam int unsigned NUM_SEGS    = 6;
	localparam int unsigned FIRST_SEG   = 4;

	// Field widths
	localparam int unsigned BIT_W    = 3;
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned PARITY_W = 11;

	// Field positions within a result word
	localparam int unsigned BIT_LSB    = 0;
	localparam int unsigned BYTE_LSB   = 3;
	localparam int unsigned PARITY_LSB = 12;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] SEG4_ADDR = 32'h0FFF_E820;
	localparam logic [ADDR_W-1:0] SEG5_ADDR = 32'h0FFF_E824;
	localparam logic [ADDR_W-1:0] SEG6_ADDR = 32'h0FFF_E828;
	localparam logic [ADDR_W-1:0] SEG7_ADDR = 32'h0FFF_E82C;
	localparam logic [ADDR_W-1:0] SEG8_ADDR = 32'h0FFF_E830;
	localparam logic [ADDR_W-1:0] SEG9_ADDR = 32'h0FFF_E834;

	// First page byte of each segment
	localparam logic [PAGE_ADDR_W-1:0] SEG4_BASE = 12'h400;
	localparam logic [PAGE_ADDR_W-1:0] SEG5_BASE = 12'h500;
	localparam logic [PAGE_ADDR_W-1:0] SEG6_BASE = 12'h600;
	localparam logic [PAGE_ADDR_W-1:0] SEG7_BASE = 12'h700;
	localparam logic [PAGE_ADDR_W-1:0] SEG8_BASE = 12'h800;
	localparam logic [PAGE_ADDR_W-1:0] SEG9_BASE = 12'h900;

	// Reset value of a result word
	localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Write channel states
	typedef enum logic [0:0] {
		NEL_WR_IDLE = 1'b0,
		NEL_WR_RESP = 1'b1
	} nel_wr_state_t;

endpackage : nel_pkg

// >>> logic/nel_seg_result.sv
/*
 * One segment's error-location result word.
 * Assumes the ECC engine presents one result pulse per segment per page
 * read, with a page byte address that falls inside the segment.
 */
`timescale 1ns/1ps

module nel_seg_result #(
	parameter logic [nel_pkg::PAGE_ADDR_W-1:0] SEG_BASE = nel_pkg::SEG4_BASE
) (
	// Clock and reset
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	// Result from the ECC engine
	input  wire logic                            res_valid,
	input  wire logic [nel_pkg::PAGE_ADDR_W-1:0] res_byte_addr,
	input  wire logic [nel_pkg::BIT_W-1:0]       res_bit,
	input  wire logic                            res_single,
	input  wire logic [nel_pkg::PARITY_W-1:0]    res_parity,
	// Stored word
	output logic      [nel_pkg::DATA_W-1:0]      result_word
);

	// Result is meant for this segment
	logic in_seg;
	// Stored fields
	logic [nel_pkg::BIT_W-1:0]    bit_loc_r;
	logic [nel_pkg::BYTE_W-1:0]   byte_loc_r;
	logic [nel_pkg::PARITY_W-1:0] parity_r;

	// Upper page address bits select the segment
	assign in_seg = (res_byte_addr[nel_pkg::PAGE_ADDR_W-1:nel_pkg::SEG_LSB]
		== SEG_BASE[nel_pkg::PAGE_ADDR_W-1:nel_pkg::SEG_LSB]);

	// Load location on a single error, parity on every result
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bit_loc_r  <= '0;
			byte_loc_r <= '0;
			parity_r   <= '0;
		end else if (res_valid && in_seg) begin
			parity_r <= res_parity;
			// Multiple errors keep old, meaningless locations
			if (res_single) begin // RL3
				bit_loc_r  <= res_bit; // RL1
				byte_loc_r <= res_byte_addr[nel_pkg::BYTE_W-1:0]; // RL2
			end
		end
	end

	// Pack fields; gaps at bits 11 and 23 up read zero
	always_comb begin
		result_word = nel_pkg::RESULT_RST;
		result_word[nel_pkg::BIT_LSB +: nel_pkg::BIT_W] = bit_loc_r; // RL11
		result_word[nel_pkg::BYTE_LSB +: nel_pkg::BYTE_W] = byte_loc_r;
		result_word[nel_pkg::PARITY_LSB +: nel_pkg::PARITY_W] = parity_r;
	end

endmodule : nel_seg_result

// >>> logic/nel_result_regs.sv
/*
 * Error-locator result registers for page segments four to nine, read by
 * software over an AXI4-Lite slave port.
 * Assumes one clock, a synchronous active-low reset, and an ECC engine
 * that reports one result per segment after each page read.
 */
// Design decision made here: the AXI4-Lite interface to the registers.
// Notes on behaviour
// RL1: Single error loads bit position in byte
// RL2: Single error loads byte index in segment
// RL3: Multiple errors leave location fields meaningless
// RL4: Segment four register covers bytes 1024-1279
// RL5: Segment five register covers bytes 1280-1535
// RL6: Segment six register covers bytes 1536-1791
// RL7: Segment seven register covers bytes 1792-2047
// RL8: Segment eight register covers bytes 2048-2303
// RL9: Segment nine register covers bytes 2304-2559
// RL10: Software saves parity into spare area
// RL11: Bit 2:0, byte 10:3, parity 22:12
// RL12: Writes to result registers are ignored
`timescale 1ns/1ps

module nel_result_regs (
	// Clock and reset
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	// Write address channel
	input  wire logic [nel_pkg::ADDR_W-1:0]      awaddr,
	input  wire logic [2:0]                      awprot,
	input  wire logic                            awvalid,
	output logic                                 awready,
	// Write data channel
	input  wire logic [nel_pkg::DATA_W-1:0]      wdata,
	input  wire logic [3:0]                      wstrb,
	input  wire logic                            wvalid,
	output logic                                 wready,
	// Write response channel
	output logic [1:0]                           bresp,
	output logic                                 bvalid,
	input  wire logic                            bready,
	// Read address channel
	input  wire logic [nel_pkg::ADDR_W-1:0]      araddr,
	input  wire logic [2:0]                      arprot,
	input  wire logic                            arvalid,
	output logic                                 arready,
	// Read data channel
	output logic [nel_pkg::DATA_W-1:0]           rdata,
	output logic [1:0]                           rresp,
	output logic                                 rvalid,
	input  wire logic                            rready,
	// Result from the ECC engine
	input  wire logic                            res_valid,
	input  wire logic [nel_pkg::PAGE_ADDR_W-1:0] res_byte_addr,
	input  wire logic [nel_pkg::BIT_W-1:0]       res_bit,
	input  wire logic                            res_single,
	input  wire logic [nel_pkg::PARITY_W-1:0]    res_parity
);

	// Segment base table, lowest segment first
	localparam logic [nel_pkg::PAGE_ADDR_W-1:0] SEG_BASES
		[nel_pkg::NUM_SEGS] = '{
		nel_pkg::SEG4_BASE, // RL4
		nel_pkg::SEG5_BASE, // RL5
		nel_pkg::SEG6_BASE, // RL6
		nel_pkg::SEG7_BASE, // RL7
		nel_pkg::SEG8_BASE, // RL8
		nel_pkg::SEG9_BASE  // RL9
	};

	// Result words of all segments
	logic [nel_pkg::DATA_W-1:0] seg_words [nel_pkg::NUM_SEGS];

	// Write channel state
	nel_pkg::nel_wr_state_t     wr_state_r;
	// Write address and data have been taken
	logic                       aw_held_r;
	logic                       w_held_r;
	// Captured write address
	logic [nel_pkg::ADDR_W-1:0] awaddr_r;
	// Registered write channel outputs
	logic                       awready_r;
	logic                       wready_r;
	logic                       bvalid_r;
	logic [1:0]                 bresp_r;

	// Registered read channel outputs
	logic                       arready_r;
	logic                       rvalid_r;
	logic [nel_pkg::DATA_W-1:0] rdata_r;
	logic [1:0]                 rresp_r;

	// Read decode results
	logic                       rd_hit;
	logic [nel_pkg::DATA_W-1:0] rd_word;
	// Write decode result
	logic                       wr_hit;

	// Unused inputs, kept for bus completeness
	logic                       unused_ok;
	assign unused_ok = ^{awprot, arprot, wdata, wstrb};

	// One result register per segment
	genvar g;
	generate
		for (g = 0; g < nel_pkg::NUM_SEGS; g++) begin : g_seg
			nel_seg_result #(
				.SEG_BASE (SEG_BASES[g])
			) u_seg (
				.aclk          (aclk),
				.aresetn       (aresetn),
				.res_valid     (res_valid),
				.res_byte_addr (res_byte_addr),
				.res_bit       (res_bit),
				.res_single    (res_single),
				.res_parity    (res_parity),
				.result_word   (seg_words[g])
			);
		end
	endgenerate

	// Read address decode into a result word
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = nel_pkg::RESULT_RST;
		case (araddr)
			// Fifth page segment
			nel_pkg::SEG4_ADDR: rd_word = seg_words[0]; // RL4
			// Sixth page segment
			nel_pkg::SEG5_ADDR: rd_word = seg_words[1]; // RL5
			// Seventh page segment
			nel_pkg::SEG6_ADDR: rd_word = seg_words[2]; // RL6
			// Eighth page segment
			nel_pkg::SEG7_ADDR: rd_word = seg_words[3]; // RL7
			// Ninth page segment
			nel_pkg::SEG8_ADDR: rd_word = seg_words[4]; // RL8
			// Tenth page segment
			nel_pkg::SEG9_ADDR: rd_word = seg_words[5]; // RL9
			// Unmapped address reads zero with an error
			default: begin
				rd_hit  = 1'b0;
				rd_word = nel_pkg::RESULT_RST;
			end
		endcase
	end

	// Write address decode; mapped words accept and ignore data
	always_comb begin
		case (awaddr_r)
			nel_pkg::SEG4_ADDR: wr_hit = 1'b1;
			nel_pkg::SEG5_ADDR: wr_hit = 1'b1;
			nel_pkg::SEG6_ADDR: wr_hit = 1'b1;
			nel_pkg::SEG7_ADDR: wr_hit = 1'b1;
			nel_pkg::SEG8_ADDR: wr_hit = 1'b1;
			nel_pkg::SEG9_ADDR: wr_hit = 1'b1;
			default:            wr_hit = 1'b0;
		endcase
	end

	// Write address channel: take one address, hold until response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awready_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (awvalid && awready_r) begin
			// Address taken; stop accepting
			aw_held_r <= 1'b1;
			awready_r <= 1'b0;
			awaddr_r  <= awaddr;
		end else if (wr_state_r == nel_pkg::NEL_WR_RESP && bready) begin
			// Response taken; open for the next write
			aw_held_r <= 1'b0;
			awready_r <= 1'b1;
		end else if (wr_state_r == nel_pkg::NEL_WR_IDLE && !aw_held_r) begin
			// Idle and empty, offer ready
			awready_r <= 1'b1;
		end
	end

	// Write data channel: take one beat, data is discarded
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wready_r <= 1'b0;
		end else if (wvalid && wready_r) begin
			// Data taken and dropped
			w_held_r <= 1'b1;
			wready_r <= 1'b0;
		end else if (wr_state_r == nel_pkg::NEL_WR_RESP && bready) begin
			// Response taken; open for the next write
			w_held_r <= 1'b0;
			wready_r <= 1'b1;
		end else if (wr_state_r == nel_pkg::NEL_WR_IDLE && !w_held_r) begin
			// Idle and empty, offer ready
			wready_r <= 1'b1;
		end
	end

	// Write response: once both halves are in, answer without storing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_r <= nel_pkg::NEL_WR_IDLE;
			bvalid_r   <= 1'b0;
			bresp_r    <= nel_pkg::RESP_OKAY;
		end else begin
			case (wr_state_r)
				// Wait for address and data
				nel_pkg::NEL_WR_IDLE: begin
					if (aw_held_r && w_held_r) begin
						wr_state_r <= nel_pkg::NEL_WR_RESP;
						bvalid_r   <= 1'b1;
						// Read-only words: okay, nothing changes RL12
						bresp_r    <= wr_hit ? nel_pkg::RESP_OKAY
							: nel_pkg::RESP_SLVERR;
					end
				end
				// Hold response until master takes it
				nel_pkg::NEL_WR_RESP: begin
					if (bready) begin
						wr_state_r <= nel_pkg::NEL_WR_IDLE;
						bvalid_r   <= 1'b0;
					end
				end
				// Recover from an illegal code
				default: begin
					wr_state_r <= nel_pkg::NEL_WR_IDLE;
					bvalid_r   <= 1'b0;
				end
			endcase
		end
	end

	// Read channel: one read at a time, data one edge after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= nel_pkg::RESULT_RST;
			rresp_r   <= nel_pkg::RESP_OKAY;
		end else if (arvalid && arready_r) begin
			// Address taken; present selected word
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rd_word;
			rresp_r   <= rd_hit ? nel_pkg::RESP_OKAY
				: nel_pkg::RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			// Data taken; open for the next read
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end else if (!rvalid_r) begin
			// Idle, offer ready
			arready_r <= 1'b1;
		end
	end

	// Outputs come straight from flops
	assign awready = awready_r;
	assign wready  = wready_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = arready_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;

endmodule : nel_result_regs

// >>> tb/nel_result_regs_checker.sv
/* Checker for the result register bus port.
   Bound onto nel_result_regs; sees only its ports. */
`timescale 1ns/1ps
module nel_result_regs_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write side
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	// Read side
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready
);
	// Read address hits one of the six words
	wire logic map_w = araddr >= nel_pkg::SEG4_ADDR &&
		araddr <= nel_pkg::SEG9_ADDR && araddr[1:0] == 2'h0;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
	sequence s_rd_take; arvalid && arready; endsequence
	property p_wr_ans; s_wr_take |-> ##1 !bvalid ##1 bvalid; endproperty
	property p_aw_drop; s_wr_take |=> (!awready && !wready) [*2]; endproperty
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	property p_rd_ans; s_rd_take |=> rvalid; endproperty
	property p_rd_map; (s_rd_take and map_w) |=> rresp == 2'h0; endproperty
	property p_rd_unmap;
		(s_rd_take and !map_w) |=> rresp == 2'h2 && rdata == 32'h0;
	endproperty
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	property p_zero_bits; rvalid |-> rdata[31:23] == 9'h0 && !rdata[11]; endproperty
	a_wr_ans: assert property (p_wr_ans)
		else $error("write answer not two edges after take");
	a_aw_drop: assert property (p_aw_drop)
		else $error("write ready back too early");
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped before taken");
	a_rd_ans: assert property (p_rd_ans)
		else $error("read answer late");
	a_rd_map: assert property (p_rd_map)
		else $error("mapped read not OKAY");
	a_rd_unmap: assert property (p_rd_unmap)
		else $error("unmapped read wrong");
	a_r_hold: assert property (p_r_hold)
		else $error("read data changed while waiting");
	a_zero_bits: assert property (p_zero_bits)
		else $error("reserved bits not zero");
endmodule : nel_result_regs_checker

bind nel_result_regs nel_result_regs_checker u_nel_result_regs_checker (.*);

// >>> tb/nel_host_model.sv
/* Host model: bus master that reads and writes the result words.
   Assumes the testbench calls its tasks one at a time. */
`timescale 1ns/1ps
module nel_host_model (
	// Clock
	input wire logic aclk,
	// Write side
	output logic [31:0] awaddr,
	output logic [2:0] awprot,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read side
	output logic [31:0] araddr,
	output logic [2:0] arprot,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// Cycles to hold off bready or rready
	int stall = 0;
	// Idle bus at time zero
	initial begin
		{awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arprot, arvalid, rready} = '0;
	end
	// Read one word; parity is fetched so software can save it
	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~a;
		repeat (stall) @(posedge aclk);
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	// Write one word, each channel released when taken
	task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
		logic aw_on;
		logic w_on;
		@(posedge aclk);
		{awaddr, wdata, wstrb} <= {a, d, 4'hF};
		{awvalid, wvalid} <= 2'h3;
		aw_on = 1'b1;
		w_on = 1'b1;
		while (aw_on || w_on) begin
			@(posedge aclk);
			if (aw_on && awready === 1'b1) begin
				aw_on = 1'b0;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (w_on && wready === 1'b1) begin
				w_on = 1'b0;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		repeat (stall) @(posedge aclk);
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
endmodule : nel_host_model

// >>> tb/nel_result_regs_tb_top.sv
/* Testbench for the result registers.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module nel_result_regs_tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [2:0] awprot, arprot;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic res_valid = 1'b0;
	logic res_single = 1'b0;
	logic [11:0] res_byte_addr = 12'h0;
	logic [2:0] res_bit = 3'h0;
	logic [10:0] res_parity = 11'h0;
	logic [31:0] ex [6];
	int n_mismatch = 0;
	int num_checks = 0;
	// Clock and devices
	always #5 aclk = ~aclk;
	nel_result_regs u_nel_result_regs (.*);
	nel_host_model u_nel_host_model (.*);
	task automatic wrap_up();
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up
	task automatic chk_word(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_resp(input logic [1:0] got, exp);
		chk_word({30'h0, got}, {30'h0, exp});
	endtask : chk_resp
	// Read a word and compare data and response
	task automatic rd_chk(input logic [31:0] a, e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		u_nel_host_model.rd(a, d, r);
		chk_word(d, e);
		chk_resp(r, er);
	endtask : rd_chk
	// One result pulse from the ECC engine
	task automatic pulse(input logic [11:0] a, input logic [2:0] b,
		input logic s, input logic [10:0] p);
		@(posedge aclk);
		{res_valid, res_byte_addr, res_bit, res_single, res_parity} <=
			{1'b1, a, b, s, p};
		@(posedge aclk);
		res_valid <= 1'b0;
	endtask : pulse
	// Every segment loaded at a byte boundary, neighbours ignored
	task automatic t_single();
		logic [7:0] by;
		for (int i = 0; i < 6; i++) begin
			by = i[0] ? 8'hFF : 8'h00;
			pulse({4'(i + 4), by}, 3'(7 - i), 1'b1, 11'(12'h400 + i));
			ex[i] = {9'h0, 11'(12'h400 + i), 1'b0, by, 3'(7 - i)};
		end
		pulse(12'h3FF, 3'h1, 1'b1, 11'h7FF);
		pulse(12'hA00, 3'h1, 1'b1, 11'h7FF);
		rd_chk(nel_pkg::SEG4_ADDR, ex[0], 2'h0);
		rd_chk(nel_pkg::SEG5_ADDR, ex[1], 2'h0);
		rd_chk(nel_pkg::SEG6_ADDR, ex[2], 2'h0);
		rd_chk(nel_pkg::SEG7_ADDR, ex[3], 2'h0);
		rd_chk(nel_pkg::SEG8_ADDR, ex[4], 2'h0);
		rd_chk(nel_pkg::SEG9_ADDR, ex[5], 2'h0);
	endtask : t_single
	// Multiple errors: parity loads, locations stay
	task automatic t_multi();
		pulse(12'h5A5, 3'h2, 1'b0, 11'h123);
		ex[1][22:12] = 11'h123;
		rd_chk(nel_pkg::SEG5_ADDR, ex[1], 2'h0);
	endtask : t_multi
	// Writes ignored, slow host, unmapped places refused
	task automatic t_write();
		logic [1:0] r;
		u_nel_host_model.stall = 3;
		u_nel_host_model.wr(nel_pkg::SEG6_ADDR, 32'hFFFF_FFFF, r);
		chk_resp(r, 2'h0);
		rd_chk(nel_pkg::SEG6_ADDR, ex[2], 2'h0);
		u_nel_host_model.wr(32'h0FFF_E838, 32'h1, r);
		chk_resp(r, 2'h2);
		rd_chk(32'h0FFF_E838, 32'h0, 2'h2);
		rd_chk(32'h0FFF_E825, 32'h0, 2'h2);
		u_nel_host_model.stall = 0;
	endtask : t_write
	// Watchdog
	initial begin
		#20us;
		n_mismatch++;
		wrap_up();
	end
	// Main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 6; i++)
			rd_chk(nel_pkg::SEG4_ADDR + 4 * i, 32'h0, 2'h0);
		t_single();
		t_multi();
		t_write();
		wrap_up();
	end
endmodule : nel_result_regs_tb_top
